// ---- design/mba_pkg.sv ----
// Shared constants and types for the bus matrix arbiter.
// What this block does
// - Route up to 16 masters to 16 slaves; each master has its own decoder.
// - New owner costs one cycle; the slave's current default owner goes straight through.
// - Sixteen general-purpose special function registers, one per slave, with no internal use.
// - With no pending request after an access, a slave follows its default-owner policy.
// - Each slave has a two-bit default owner kind: none, last, fixed.
// - Each slave has a four-bit fixed owner index, used only under the fixed kind.
// - No default owner: an idle slave disconnects from every master.
// - Last owner: an idle slave stays with the master that last requested it.
// - Fixed owner: an idle slave returns to the programmed master; only software changes it.
// - Each slave has its own arbiter, round-robin by default or fixed priority.
// - Ownership changes only on idle, single, burst-end or slot-expiry cycles.
// - Per master, open bursts predict an end never, every beat, or every 4/8/16 beats.
// - The infinite setting never predicts an end; only slot expiry can break such an open burst.
// - Slot counter loads at burst start, counts down each clock, allows re-arbitration at zero.
// - Round-robin serves the lowest master first, then rotates.
// - Round-robin without default owner costs one cycle on every first access.
// - Round-robin with last owner: that master has zero latency, others one cycle.
// - Round-robin with fixed owner: that master has zero latency, others one cycle.
// - Fixed priority grants the highest priority value first.
// - Equal priorities go to the highest master index.
// - Per-slave priority registers A and B hold each master's priority.
// - Master configuration registers reset to 0x00000002.
package mba_pkg;

  localparam int MBA_N = 16;
  localparam int MBA_IW = 4;

  // Configuration register indices (printed byte offset divided by four).
  localparam logic [6:0] MBA_IDX_MASTER_CONFIG_REG = 7'h00;
  localparam logic [6:0] MBA_IDX_SLAVE_CONFIG_REG = 7'h10;
  localparam logic [6:0] MBA_IDX_PRI = 7'h20;
  localparam logic [6:0] MBA_IDX_SFR = 7'h44;

  localparam logic [31:0] MBA_MASTER_CONFIG_REG_RST = 32'h00000002;
  localparam logic [31:0] MBA_SLAVE_CONFIG_REG_RST = 32'h00000010;
  localparam logic [31:0] MBA_PRI_RST = 32'h00000000;
  localparam logic [31:0] MBA_SFR_RST = 32'h00000000;

  // Field positions.
  localparam int MBA_OPEN_BURST_BREAK_SIZE_LSB = 0;
  localparam int MBA_SLOT_LSB = 0;
  localparam int MBA_DEFK_LSB = 16;
  localparam int MBA_FIXI_LSB = 18;
  localparam int MBA_ARBITRATION_KIND_BIT = 24;
  localparam int MBA_PRI_STRIDE = 4;
  localparam int MBA_DEC_LSB = 28;

  typedef enum logic [1:0] {
    MBA_DEF_NONE = 2'h0,
    MBA_DEF_LAST = 2'h1,
    MBA_DEF_FIXED = 2'h2
  } mba_defk_t;

  typedef enum logic [2:0] {
    MBA_OPEN_BURST_BREAK_SIZE_INF = 3'h0,
    MBA_OPEN_BURST_BREAK_SIZE_ONE = 3'h1,
    MBA_OPEN_BURST_BREAK_SIZE_FOUR = 3'h2,
    MBA_OPEN_BURST_BREAK_SIZE_EIGHT = 3'h3,
    MBA_OPEN_BURST_BREAK_SIZE_SIXTEEN = 3'h4
  } mba_open_burst_break_size_t;

  typedef enum logic [1:0] {
    MBA_KIND_SINGLE = 2'h0,
    MBA_KIND_INCR = 2'h1,
    MBA_KIND_FIXLEN = 2'h2
  } mba_kind_t;

  // One master's transfer request.
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    mba_kind_t kind;
    logic last;
  } mba_req_t;

  // One software write into the configuration space.
  typedef struct packed {
    logic en;
    logic [6:0] idx;
    logic [31:0] data;
  } mba_cfg_wr_t;

endpackage : mba_pkg

// ---- design/mba_slave_arb.sv ----
// Per-slave winner selection, round-robin or fixed priority.
`timescale 1ns/1ps
`default_nettype none
module mba_slave_arb import mba_pkg::*; (
  input wire logic [MBA_N-1:0] req,
  input wire logic [MBA_IW-1:0] rr_ptr,
  input wire logic fixed_prio,
  input wire logic [63:0] prio,
  output logic [MBA_IW-1:0] winner
);

  // Scans are short loops; the tree depth is acceptable at 50 MHz.
  always_comb begin
    logic found;
    logic [3:0] best;
    logic [3:0] cand;
    logic [3:0] idx;
    cand = 4'h0;
    idx = 4'h0;
    found = 1'b0;
    best = 4'h0;
    winner = '0;
    for (int i = 0; i < MBA_N; i++) begin
      idx = MBA_IW'(i);
      cand = prio[i*MBA_PRI_STRIDE +: 4];
      if (fixed_prio) begin
        // Ties go upward because later indices overwrite on equal values.
        if (req[i] && (!found || cand >= best)) begin
          winner = idx;
          best = cand;
          found = 1'b1;
        end
      end
    end
    if (!fixed_prio) begin
      for (int k = 1; k <= MBA_N; k++) begin
        idx = MBA_IW'(rr_ptr + MBA_IW'(k));
        if (!found && req[idx]) begin
          winner = idx;
          found = 1'b1;
        end
      end
    end
  end

endmodule : mba_slave_arb
`default_nettype wire

// ---- design/mba_burst_pred.sv ----
// Per-master beat counter giving a predicted end of an open burst.
`timescale 1ns/1ps
`default_nettype none
module mba_burst_pred import mba_pkg::*; (
  input wire logic clock,
  input wire logic rst,
  input wire logic beat,
  input wire logic incr,
  input wire logic last,
  input wire logic [2:0] open_burst_break_size,
  output logic pred_end
);

  logic [3:0] cnt_r;

  // Boundary hit on the beat that completes each group.
  always_comb begin
    case (open_burst_break_size)
      MBA_OPEN_BURST_BREAK_SIZE_INF: pred_end = 1'b0;
      MBA_OPEN_BURST_BREAK_SIZE_ONE: pred_end = beat && incr;
      MBA_OPEN_BURST_BREAK_SIZE_FOUR: pred_end = beat && incr && (cnt_r[1:0] == 2'h3);
      MBA_OPEN_BURST_BREAK_SIZE_EIGHT: pred_end = beat && incr && (cnt_r[2:0] == 3'h7);
      MBA_OPEN_BURST_BREAK_SIZE_SIXTEEN: pred_end = beat && incr && (cnt_r == 4'hf);
      default: pred_end = 1'b0;
    endcase
  end

  // The count wraps freely so boundaries stay aligned to the burst start.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
    end else if (beat) begin
      if (last || !incr) begin
        cnt_r <= 4'h0;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

endmodule : mba_burst_pred
`default_nettype wire

// ---- design/mba_matrix.sv ----
// Bus matrix top: decoders, per-slave arbiters, default owners and configuration.
`timescale 1ns/1ps
`default_nettype none
module mba_matrix import mba_pkg::*; (
  input wire logic clock,
  input wire logic rst,
  input wire mba_req_t [MBA_N-1:0] mst_req,
  input wire mba_cfg_wr_t cfg_wr,
  output logic [MBA_N-1:0] mst_ready,
  output logic [MBA_N-1:0] slv_connected,
  output logic [MBA_N-1:0][MBA_IW-1:0] slv_owner,
  output logic [MBA_N-1:0][31:0] special_function_reg
);

  // Address decoder; one copy is instantiated per master.
  function automatic logic [MBA_IW-1:0] mba_decode(input logic [31:0] addr);
    mba_decode = addr[MBA_DEC_LSB +: MBA_IW];
  endfunction : mba_decode

  // Register index decode used by every configuration group.
  function automatic logic mba_hit(input mba_cfg_wr_t w, input logic [6:0] idx);
    mba_hit = w.en && (w.idx == idx);
  endfunction : mba_hit

  // Configuration storage.
  logic [MBA_N-1:0][2:0] open_burst_break_size_r;
  logic [MBA_N-1:0][31:0] slave_config_reg_r;
  logic [MBA_N-1:0][31:0] slave_priority_reg_a_r;
  logic [MBA_N-1:0][31:0] slave_priority_reg_b_r;
  logic [MBA_N-1:0][31:0] sfr_r;

  // Per-slave connection state.
  logic [MBA_N-1:0][MBA_IW-1:0] owner_r;
  logic [MBA_N-1:0][MBA_IW-1:0] owner_nxt;
  logic [MBA_N-1:0] conn_r;
  logic [MBA_N-1:0] conn_nxt;
  logic [MBA_N-1:0][MBA_IW-1:0] rr_ptr_r;
  logic [MBA_N-1:0][MBA_IW-1:0] rr_ptr_nxt;
  logic [MBA_N-1:0][7:0] slot_r;
  logic [MBA_N-1:0][7:0] slot_nxt;
  logic [MBA_N-1:0][MBA_IW-1:0] winner;
  logic [MBA_N-1:0][MBA_N-1:0] req_vec;

  // Per-master derived signals.
  logic [MBA_N-1:0][MBA_IW-1:0] target;
  logic [MBA_N-1:0] beat;
  logic [MBA_N-1:0] pred_end;
  logic [MBA_N-1:0] ready_nxt;
  logic [MBA_N-1:0] ready_r;

  genvar gm;
  genvar gs;

  // Master side: decode, beat completion and burst end prediction.
  generate
    for (gm = 0; gm < MBA_N; gm++) begin : g_mst
      // Each master decodes its own address, so paths to distinct slaves run in parallel.
      assign target[gm] = mba_decode(mst_req[gm].addr);
      // A beat completes when the held request meets a ready cycle.
      assign beat[gm] = mst_req[gm].valid && ready_r[gm];

      mba_burst_pred u_pred (
        .clock(clock),
        .rst(rst),
        .beat(beat[gm]),
        .incr(mst_req[gm].kind == MBA_KIND_INCR),
        .last(mst_req[gm].last),
        .open_burst_break_size(open_burst_break_size_r[gm]),
        .pred_end(pred_end[gm])
      );

      // Master configuration register; the burst break field resets to four beats.
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          open_burst_break_size_r[gm] <= MBA_MASTER_CONFIG_REG_RST[2:0];
        end else if (mba_hit(cfg_wr, MBA_IDX_MASTER_CONFIG_REG + 7'(gm))) begin
          open_burst_break_size_r[gm] <= cfg_wr.data[MBA_OPEN_BURST_BREAK_SIZE_LSB +: 3];
        end
      end

      // Ready only for an owner that was already connected last cycle and stays so.
      // A fresh grant therefore shows one wait cycle, while the default owner
      // keeps its connection and is answered on the next edge.
      // A beat that ends the transfer raises no further ready, because the master may
      // drop or retarget its request right after it and must not see a stray beat.
      assign ready_nxt[gm] = mst_req[gm].valid
                           && conn_r[target[gm]] && (owner_r[target[gm]] == MBA_IW'(gm))
                           && conn_nxt[target[gm]] && (owner_nxt[target[gm]] == MBA_IW'(gm))
                           && !(beat[gm] && (mst_req[gm].kind == MBA_KIND_SINGLE
                                             || mst_req[gm].last));

      // The request is only presented while valid; it is held until ready.
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          ready_r[gm] <= 1'b0;
        end else begin
          ready_r[gm] <= ready_nxt[gm];
        end
      end
    end
  endgenerate

  // Slave side: one arbiter and one connection state per slave.
  generate
    for (gs = 0; gs < MBA_N; gs++) begin : g_slv
      logic [1:0] defk;
      logic [MBA_IW-1:0] fixed_owner_index;
      logic arbitration_kind;
      logic [7:0] slot_cycle;
      logic active;
      logic done;
      logic may_switch;

      assign defk = slave_config_reg_r[gs][MBA_DEFK_LSB +: 2];
      assign fixed_owner_index = slave_config_reg_r[gs][MBA_FIXI_LSB +: MBA_IW];
      assign arbitration_kind = slave_config_reg_r[gs][MBA_ARBITRATION_KIND_BIT];
      assign slot_cycle = slave_config_reg_r[gs][MBA_SLOT_LSB +: 8];

      // Request vector for this slave, gathered across every master decoder.
      for (gm = 0; gm < MBA_N; gm++) begin : g_req
        assign req_vec[gs][gm] = mst_req[gm].valid && (target[gm] == MBA_IW'(gs));
      end

      mba_slave_arb u_arb (
        .req(req_vec[gs]),
        .rr_ptr(rr_ptr_r[gs]),
        .fixed_prio(arbitration_kind),
        .prio({slave_priority_reg_b_r[gs], slave_priority_reg_a_r[gs]}),
        .winner(winner[gs])
      );

      // The owner is busy while connected and still requesting this slave.
      assign active = conn_r[gs] && req_vec[gs][owner_r[gs]];
      assign done = active && beat[owner_r[gs]];

      // Allowed switch points; a burst is never cut in the middle of a beat.
      always_comb begin
        may_switch = !active;
        if (done) begin
          if (mst_req[owner_r[gs]].kind == MBA_KIND_SINGLE) begin
            may_switch = 1'b1;
          end else if (mst_req[owner_r[gs]].last || pred_end[owner_r[gs]]) begin
            may_switch = 1'b1;
          end else if (slot_r[gs] == 8'h00) begin
            may_switch = 1'b1;
          end
        end
      end

      // Next owner: arbitrate among requests, else fall back to the default policy.
      always_comb begin
        owner_nxt[gs] = owner_r[gs];
        conn_nxt[gs] = conn_r[gs];
        rr_ptr_nxt[gs] = rr_ptr_r[gs];
        if (may_switch) begin
          if (|req_vec[gs]) begin
            owner_nxt[gs] = winner[gs];
            conn_nxt[gs] = 1'b1;
            rr_ptr_nxt[gs] = winner[gs];
          end else begin
            case (defk)
              MBA_DEF_NONE: begin
                conn_nxt[gs] = 1'b0;
              end
              MBA_DEF_LAST: begin
                conn_nxt[gs] = conn_r[gs];
              end
              MBA_DEF_FIXED: begin
                owner_nxt[gs] = fixed_owner_index;
                conn_nxt[gs] = 1'b1;
              end
              default: begin
                conn_nxt[gs] = 1'b0;
              end
            endcase
          end
        end
      end

      // Slot counter: loads when a burst starts, then runs down to zero.
      always_comb begin
        slot_nxt[gs] = slot_r[gs];
        if (conn_nxt[gs] && (!conn_r[gs] || owner_nxt[gs] != owner_r[gs])) begin
          slot_nxt[gs] = slot_cycle;
        end else if (done && mst_req[owner_r[gs]].last) begin
          slot_nxt[gs] = slot_cycle;
        end else if (slot_r[gs] != 8'h00) begin
          slot_nxt[gs] = slot_r[gs] - 8'h01;
        end
      end

      // Connection state; the round-robin pointer starts at the top so master 0 wins first.
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          owner_r[gs] <= '0;
          conn_r[gs] <= 1'b0;
          rr_ptr_r[gs] <= 4'hf;
          slot_r[gs] <= 8'h00;
        end else begin
          owner_r[gs] <= owner_nxt[gs];
          conn_r[gs] <= conn_nxt[gs];
          rr_ptr_r[gs] <= rr_ptr_nxt[gs];
          slot_r[gs] <= slot_nxt[gs];
        end
      end

      // Slave configuration; the fixed owner moves only on this write.
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          slave_config_reg_r[gs] <= MBA_SLAVE_CONFIG_REG_RST;
        end else if (mba_hit(cfg_wr, MBA_IDX_SLAVE_CONFIG_REG + 7'(gs))) begin
          slave_config_reg_r[gs] <= cfg_wr.data;
        end
      end

      // Priority registers A and B sit interleaved, A first.
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          slave_priority_reg_a_r[gs] <= MBA_PRI_RST;
          slave_priority_reg_b_r[gs] <= MBA_PRI_RST;
        end else begin
          if (mba_hit(cfg_wr, MBA_IDX_PRI + 7'(2 * gs))) begin
            slave_priority_reg_a_r[gs] <= cfg_wr.data;
          end
          if (mba_hit(cfg_wr, MBA_IDX_PRI + 7'(2 * gs + 1))) begin
            slave_priority_reg_b_r[gs] <= cfg_wr.data;
          end
        end
      end

      // General-purpose register; the matrix itself never reads it.
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          sfr_r[gs] <= MBA_SFR_RST;
        end else if (mba_hit(cfg_wr, MBA_IDX_SFR + 7'(gs))) begin
          sfr_r[gs] <= cfg_wr.data;
        end
      end
    end
  endgenerate

  // All outputs come straight from flip-flops.
  assign mst_ready = ready_r;
  assign slv_connected = conn_r;
  assign slv_owner = owner_r;
  assign special_function_reg = sfr_r;

endmodule : mba_matrix
`default_nettype wire

// ---- testbench/mba_master_model.sv ----
// Bus master model that issues single transfers and bursts towards the matrix.
`timescale 1ns/1ps
`default_nettype none
module mba_master_model import mba_pkg::*; (
  input wire logic clock,
  input wire logic rst,
  input wire logic go,
  input wire logic [3:0] slv,
  input wire logic [4:0] beats,
  input wire logic [1:0] kind,
  input wire logic ready,
  output var mba_req_t req
);
  logic [4:0] left_r;
  // A request is held unchanged until ready is sampled high, so no beat is lost.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      req <= '0;
      left_r <= '0;
    end else if (go) begin
      req <= '{1'b1, {slv, 28'h0000000}, mba_kind_t'(kind), beats == 5'h01};
      left_r <= beats;
    end else if (req.valid && ready) begin
      left_r <= left_r - 5'h01;
      req.last <= (left_r == 5'h02);
      // A released address is inverted, since a stale target must not look valid.
      if (left_r == 5'h01) begin
        req.valid <= 1'b0;
        req.addr <= ~req.addr;
      end
    end
  end
endmodule : mba_master_model
`default_nettype wire

// ---- testbench/mba_matrix_props.sv ----
// Concurrent checks on the bus matrix ports.
`timescale 1ns/1ps
`default_nettype none
module mba_matrix_props import mba_pkg::*; (
  input wire logic clock,
  input wire logic rst,
  input wire mba_req_t [MBA_N-1:0] mst_req,
  input wire mba_cfg_wr_t cfg_wr,
  input wire logic [MBA_N-1:0] mst_ready,
  input wire logic [MBA_N-1:0] slv_connected,
  input wire logic [MBA_N-1:0][MBA_IW-1:0] slv_owner,
  input wire logic [MBA_N-1:0][31:0] special_function_reg
);
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (rst);
  logic [MBA_N-1:0][1:0] defk_r;
  logic [MBA_N-1:0][3:0] fixi_r;
  logic [MBA_N-1:0] idle;
  // Shadow of the default-owner fields, because the design has no read-back path.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      defk_r <= '0;
      fixi_r <= '0;
    end else if (cfg_wr.en && cfg_wr.idx[6:4] == 3'h1) begin
      defk_r[cfg_wr.idx[3:0]] <= cfg_wr.data[17:16];
      fixi_r[cfg_wr.idx[3:0]] <= cfg_wr.data[21:18];
    end
  end
  // A slave is idle while no master presents a request to it.
  always_comb begin
    idle = '1;
    for (int m = 0; m < MBA_N; m++) begin
      if (mst_req[m].valid) begin
        idle[mst_req[m].addr[31:28]] = 1'b0;
      end
    end
  end
  chk_sfr_update: assert property (cfg_wr.en && cfg_wr.idx inside {[7'h44:7'h53]} |=>
    special_function_reg[4'($past(cfg_wr.idx) - 7'h44)] == $past(cfg_wr.data))
    else $error("special register missed its write");
  chk_sfr_hold: assert property (!cfg_wr.en |=> $stable(special_function_reg))
    else $error("special register changed without a write");
  for (genvar m = 0; m < MBA_N; m++) begin : g_mst
    chk_ready_owner: assert property (mst_ready[m] |-> mst_req[m].valid &&
      slv_connected[mst_req[m].addr[31:28]] && slv_owner[mst_req[m].addr[31:28]] == 4'(m))
      else $error("ready given to a master that does not own its slave");
    chk_ready_cause: assert property (mst_ready[m] |-> $past(mst_req[m].valid))
      else $error("ready without a request one cycle earlier");
    chk_fresh_wait: assert property ($rose(mst_req[m].valid) && !(slv_connected[
      mst_req[m].addr[31:28]] && slv_owner[mst_req[m].addr[31:28]] == 4'(m)) |=> !mst_ready[m])
      else $error("new owner served without the connection cycle");
  end
  for (genvar s = 0; s < MBA_N; s++) begin : g_slv
    chk_none_drop: assert property (
      (idle[s] && (defk_r[s] == 2'h0 || defk_r[s] == 2'h3))[*3] |-> !slv_connected[s])
      else $error("idle slave kept a master with no default owner");
    chk_last_keep: assert property (idle[s] && defk_r[s] == 2'h1 |=>
      $stable(slv_connected[s]) && $stable(slv_owner[s]))
      else $error("idle slave left its last owner");
    chk_fixed_home: assert property (
      (idle[s] && defk_r[s] == 2'h2 && $stable(fixi_r[s]))[*3] |->
      slv_connected[s] && slv_owner[s] == fixi_r[s])
      else $error("idle slave not with its fixed owner");
  end
endmodule : mba_matrix_props
`default_nettype wire

// ---- testbench/tb_mba_matrix.sv ----
// Self-checking bench for the bus matrix arbiter.
`timescale 1ns/1ps
`default_nettype none
module tb_mba_matrix import mba_pkg::*;;
  logic clock;
  logic rst;
  wire mba_req_t [MBA_N-1:0] mst_req;
  mba_cfg_wr_t cfg_wr;
  logic [MBA_N-1:0] mst_ready;
  logic [MBA_N-1:0] slv_connected;
  logic [MBA_N-1:0][MBA_IW-1:0] slv_owner;
  logic [MBA_N-1:0][31:0] special_function_reg;
  logic [MBA_N-1:0] go;
  logic [MBA_N-1:0][3:0] slv;
  logic [MBA_N-1:0][4:0] beats;
  logic [MBA_N-1:0][1:0] kind;
  int n_errors = 0;
  int tests_run = 0;

  mba_matrix mba_matrix_inst (.clock(clock), .rst(rst), .mst_req(mst_req), .cfg_wr(cfg_wr),
    .mst_ready(mst_ready), .slv_connected(slv_connected), .slv_owner(slv_owner),
    .special_function_reg(special_function_reg));

  // One master model on every matrix input.
  for (genvar m = 0; m < MBA_N; m++) begin : g_mst
    mba_master_model mba_master_model_inst (.clock(clock), .rst(rst), .go(go[m]),
      .slv(slv[m]), .beats(beats[m]), .kind(kind[m]), .ready(mst_ready[m]), .req(mst_req[m]));
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // Inputs always move one nanosecond after the rising edge.
  task automatic tick(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask : tick

  task automatic cfg(input logic [6:0] idx, input logic [31:0] data);
    cfg_wr = '{1'b1, idx, data};
    tick(1);
    cfg_wr.en = 1'b0;
    tick(1);
  endtask : cfg

  task automatic start(input int m, input logic [3:0] s, input logic [4:0] b, input mba_kind_t k);
    go[m] = 1'b1;
    slv[m] = s;
    beats[m] = b;
    kind[m] = k;
  endtask : start

  // Edges from launch to ready: two for the attached owner, three for anyone else.
  task automatic lat(input int m, input logic [3:0] s, input int exp);
    int c;
    start(m, s, 5'h01, MBA_KIND_SINGLE);
    tick(1);
    go = '0;
    for (c = 1; c < 40 && mst_ready[m] !== 1'b1; c++) begin
      tick(1);
    end
    check(c, exp);
    tick(4);
  endtask : lat

  // Three masters ask one slave together; the grant order is packed into nibbles.
  task automatic arb3(input logic [3:0] s, input int a, b, c, input logic [11:0] exp);
    logic [11:0] order;
    int k;
    order = '0;
    k = 0;
    start(a, s, 5'h01, MBA_KIND_SINGLE);
    start(b, s, 5'h01, MBA_KIND_SINGLE);
    start(c, s, 5'h01, MBA_KIND_SINGLE);
    tick(1);
    go = '0;
    for (int t = 0; t < 40 && k < 3; t++) begin
      for (int m = 0; m < MBA_N; m++) begin
        if (mst_ready[m] === 1'b1) begin
          order = {order[7:0], 4'(m)};
          k++;
        end
      end
      tick(1);
    end
    check(order, exp);
    tick(3);
  endtask : arb3

  // Master 1 streams twelve beats while master 8 waits for the same slave.
  // Master 1 starts one cycle ahead so it owns the slave whatever the rotation state.
  task automatic brk(input logic [3:0] s, input mba_kind_t k, output int nb);
    start(1, s, 5'h0c, k);
    tick(1);
    go[1] = 1'b0;
    start(8, s, 5'h01, MBA_KIND_SINGLE);
    tick(1);
    go = '0;
    nb = 0;
    for (int t = 0; t < 60 && mst_ready[8] !== 1'b1; t++) begin
      nb += (mst_ready[1] === 1'b1);
      tick(1);
    end
    check(mst_ready[8], 1'b1);
    tick(40);
  endtask : brk

  task automatic t_sfr();
    check(slv_connected, 32'h0);
    check(special_function_reg[9], 32'h0);
    cfg(7'h49, 32'h5a5a0009);
    cfg(7'h53, 32'h0000c3c3);
    cfg(7'h43, 32'hffffffff);
    cfg(7'h54, 32'hffffffff);
    check(special_function_reg[5], 32'h5a5a0009);
    check(special_function_reg[15], 32'h0000c3c3);
    check(special_function_reg[0], 32'h0);
  endtask : t_sfr

  // Slave 2 walks through the three default-owner kinds.
  task automatic t_default();
    lat(3, 4'h2, 3);
    check(slv_connected[2], 1'b0);
    cfg(7'h12, 32'h00010010);
    lat(3, 4'h2, 3);
    lat(3, 4'h2, 2);
    lat(5, 4'h2, 3);
    check({slv_connected[2], slv_owner[2]}, {1'b1, 4'h5});
    cfg(7'h12, 32'h001e0010);
    tick(2);
    check({slv_connected[2], slv_owner[2]}, {1'b1, 4'h7});
    lat(7, 4'h2, 2);
    lat(2, 4'h2, 3);
    check({slv_connected[2], slv_owner[2]}, {1'b1, 4'h7});
    cfg(7'h12, 32'h00030010);
    tick(2);
    check(slv_connected[2], 1'b0);
    cfg(7'h12, 32'h00000010);
    tick(2);
    check(slv_connected[2], 1'b0);
  endtask : t_default

  task automatic t_prio();
    cfg(7'h15, 32'h01000010);
    cfg(7'h2a, 32'h00010300);
    cfg(7'h2b, 32'h00000300);
    arb3(4'h5, 2, 4, 10, 12'ha24);
  endtask : t_prio

  // Break sizes of open bursts on slave 6, then a short slot limit on slave 7.
  task automatic t_burst();
    logic [2:0] ub [4] = '{3'h0, 3'h1, 3'h3, 3'h4};
    int ex [4] = '{12, 1, 8, 12};
    int nb;
    brk(4'h6, MBA_KIND_INCR, nb);
    check(nb, 4);
    for (int i = 0; i < 4; i++) begin
      cfg(7'h01, {29'h0, ub[i]});
      brk(4'h6, MBA_KIND_INCR, nb);
      check(nb, ex[i]);
    end
    cfg(7'h17, 32'h00000003);
    brk(4'h7, MBA_KIND_INCR, nb);
    check(nb inside {[2:4]}, 1'b1);
    // A fixed-length burst is cut only at its last beat or at slot expiry, whatever the break setting.
    cfg(7'h01, 32'h00000001);
    brk(4'h6, MBA_KIND_FIXLEN, nb);
    check(nb, 12);
  endtask : t_burst

  // The bus clock runs from time zero.
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Reset for three cycles, then every scenario in turn.
  initial begin
    rst = 1'b1;
    go = '0;
    slv = '0;
    beats = '0;
    kind = '0;
    cfg_wr = '0;
    tick(3);
    rst = 1'b0;
    tick(1);
    t_sfr();
    t_default();
    arb3(4'h4, 1, 6, 9, 12'h169);
    t_prio();
    t_burst();
    summarize();
  end

  // The tests need well under two thousand cycles, so a hang is cut short here.
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    summarize();
  end
endmodule : tb_mba_matrix

bind mba_matrix mba_matrix_props mba_matrix_props_inst (.clock(clock), .rst(rst),
  .mst_req(mst_req), .cfg_wr(cfg_wr), .mst_ready(mst_ready), .slv_connected(slv_connected),
  .slv_owner(slv_owner), .special_function_reg(special_function_reg));
`default_nettype wire
